// >>> verilog/clksr_pkg.sv
package clksr_pkg;

    // ========================================================================
    // register map (index = printed offset, byte address = 4 * index)
    // ========================================================================
    localparam int         ADDR_W    = 12;
    localparam logic [9:0] IDX_PLL   = 10'h010;
    localparam logic [9:0] IDX_CAL   = 10'h018;
    localparam logic [9:0] IDX_VDIV  = 10'h1E0;
    localparam logic [9:0] IDX_ROUTE = 10'h1E1;
    localparam logic [9:0] IDX_UPD   = 10'h232;
    localparam logic [9:0] IDX_STAT  = 10'h240;

    // one-hot select positions
    localparam int SEL_PLL   = 0;
    localparam int SEL_CAL   = 1;
    localparam int SEL_VDIV  = 2;
    localparam int SEL_ROUTE = 3;
    localparam int SEL_UPD   = 4;
    localparam int SEL_STAT  = 5;

    // ========================================================================
    // field positions
    // ========================================================================
    localparam int POS_PD   = 0;
    localparam int POS_POL  = 7;
    localparam int POS_CAL  = 0;
    localparam int POS_RAT  = 0;
    localparam int POS_BYP  = 0;
    localparam int POS_SRC  = 1;
    localparam int POS_UPD  = 0;

    // ========================================================================
    // reset values and encodings
    // ========================================================================
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [1:0] RST_PD    = 2'h1;
    localparam logic [2:0] RST_RATIO = 3'h2;
    localparam logic       RST_BYP   = 1'b0;
    localparam logic       RST_SRC   = 1'b0;
    localparam logic       RST_POL   = 1'b0;
    localparam logic       RST_CAL   = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DEC  = 2'h3;
    localparam logic [2:0] DIV_MIN   = 3'h2;

    // calibration run length in aclk cycles
    localparam logic [15:0] CAL_CYCLES_DEF = 16'h0040;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b01,
        CAL_RUN  = 2'b10
    } clksr_cal_st_t;

    function automatic logic [5:0] clksr_dec(input logic [ADDR_W-1:0] a);
        logic [5:0] s;
        s            = 6'h00;
        s[SEL_PLL]   = (a == {IDX_PLL, 2'b00});
        s[SEL_CAL]   = (a == {IDX_CAL, 2'b00});
        s[SEL_VDIV]  = (a == {IDX_VDIV, 2'b00});
        s[SEL_ROUTE] = (a == {IDX_ROUTE, 2'b00});
        s[SEL_UPD]   = (a == {IDX_UPD, 2'b00});
        s[SEL_STAT]  = (a == {IDX_STAT, 2'b00});
        return s;
    endfunction

    // unused codes above 100b clamp to the largest ratio
    function automatic logic [2:0] clksr_div_of(input logic [2:0] code);
        case (code)
            3'h0:    return 3'h2;
            3'h1:    return 3'h3;
            3'h2:    return 3'h4;
            3'h3:    return 3'h5;
            default: return 3'h6;
        endcase
    endfunction

endpackage

// >>> verilog/clksr_div.sv
`timescale 1ns/10ps
module clksr_div
(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // source and settings
    input  wire logic       src_lvl,
    input  wire logic [2:0] ratio,
    input  wire logic       bypass,
    // distribution clock
    output logic            dist_clk
);
    // ========================================================================
    // source edge counter
    // ========================================================================
    logic       prev_ff;
    logic [2:0] cnt_ff;
    logic       out_ff;
    logic [2:0] div_w;
    logic       rise_w;
    logic [2:0] nxt_cnt;
    logic       nxt_out;

    assign div_w    = clksr_pkg::clksr_div_of(ratio);
    assign rise_w   = src_lvl & ~prev_ff;
    // a smaller ratio can leave the count past its end: restart at once
    assign nxt_cnt  = (cnt_ff >= div_w) ? 3'h0 : !rise_w ? cnt_ff : (cnt_ff >= div_w - 3'h1) ? 3'h0 : cnt_ff + 3'h1;
    // high for the lower half of the count; bypass passes the source level through instead
    assign nxt_out  = bypass ? src_lvl : (nxt_cnt < (div_w >> 1));
    assign dist_clk = out_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prev_ff <= 1'b0;
            cnt_ff  <= 3'h0;
            out_ff  <= 1'b0;
        end
        else
        begin
            prev_ff <= src_lvl;
            cnt_ff  <= nxt_cnt;
            out_ff  <= nxt_out;
        end
    end

    // ========================================================================
    // checks
    // ========================================================================
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_div_range;
        // one cycle of grace while a new ratio settles
        div_w >= clksr_pkg::DIV_MIN && ($changed(ratio) || cnt_ff < div_w);
    endproperty
    a_div_range: assert property (p_div_range) else $error("divider count out of range");

    property p_bypass;
        bypass && $stable(bypass) |-> out_ff == $past(src_lvl);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass does not follow source");

    property p_wrap;
        rise_w && cnt_ff == div_w - 3'h1 && $stable(ratio) |=> cnt_ff == 3'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("divider count did not wrap");

    c_div_mode: cover property (!bypass && rise_w && cnt_ff == 3'h3);

endmodule

// >>> verilog/clksr_cal.sv
`timescale 1ns/10ps
module clksr_cal
#(
    parameter logic [15:0] CAL_CYCLES = clksr_pkg::CAL_CYCLES_DEF
)
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // active calibrate bit
    input  wire logic cal_bit,
    // calibration engine
    output logic      cal_start,
    output logic      cal_busy
);
    // ========================================================================
    // rising-edge start and run timer
    // ========================================================================
    clksr_pkg::clksr_cal_st_t st_ff;
    clksr_pkg::clksr_cal_st_t nxt_st;
    logic        prev_ff;
    logic        start_ff;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic        rise_w;

    // prev resets low, so the first set after reset already starts a run
    assign rise_w = cal_bit & ~prev_ff;

    always_comb
    begin
        nxt_st  = st_ff;
        nxt_cnt = cnt_ff;
        case (st_ff)
            clksr_pkg::CAL_IDLE:
            begin
                if (rise_w)
                begin
                    nxt_st  = clksr_pkg::CAL_RUN;
                    nxt_cnt = CAL_CYCLES;
                end
            end
            clksr_pkg::CAL_RUN:
            begin
                // a new edge mid-run restarts the timer
                if (rise_w)
                    nxt_cnt = CAL_CYCLES;
                else if (cnt_ff <= 16'h0001)
                begin
                    nxt_st  = clksr_pkg::CAL_IDLE;
                    nxt_cnt = 16'h0000;
                end
                else
                    nxt_cnt = cnt_ff - 16'h0001;
            end
            default:
            begin
                nxt_st  = clksr_pkg::CAL_IDLE;
                nxt_cnt = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff    <= clksr_pkg::CAL_IDLE;
            cnt_ff   <= 16'h0000;
            prev_ff  <= 1'b0;
            start_ff <= 1'b0;
        end
        else
        begin
            st_ff    <= nxt_st;
            cnt_ff   <= nxt_cnt;
            prev_ff  <= cal_bit;
            start_ff <= rise_w;
        end
    end

    assign cal_start = start_ff;
    assign cal_busy  = (st_ff == clksr_pkg::CAL_RUN);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_cal_start;
        $rose(cal_bit) |=> cal_start && cal_busy;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("calibration did not start on edge");

    c_cal_run: cover property (cal_start);

endmodule

// >>> verilog/clksr_ctrl.sv
`timescale 1ns/10ps
// Notes on behaviour
// - reset: pll powered down, external clock divided
// - reset loads ratio 010b, divider used, external
// - three-bit ratio selects divide 2 to 6
// - bypass bit 1 passes source straight through
// - source select 1 internal vco, 0 external
// - divider path never divides by less than 2
// - external selected with pll on: vco off
// - power-down 00b normal, 01b powered down
// - polarity bit 0 positive, 1 negative
module clksr_ctrl
#(
    parameter logic [15:0] CAL_CYCLES = clksr_pkg::CAL_CYCLES_DEF
)
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // axi4-lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi4-lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // clock source pins
    input  wire logic        ext_clk_in,
    input  wire logic        vco_clk_in,
    // distribution and analog controls
    output logic             dist_clk,
    output logic [1:0]       pll_pd_field,
    output logic             pll_powerdown,
    output logic             pfd_pol_neg,
    output logic             vco_power_en,
    output logic             prescaler_ext_sel,
    output logic             vco_cal_start,
    output logic             vco_cal_busy
);
    // ========================================================================
    // axi4-lite slave
    // ========================================================================
    logic        aw_hold_ff;
    logic [11:0] awaddr_ff;
    logic        w_hold_ff;
    logic [31:0] wdata_ff;
    logic        wstrb0_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        do_wr;
    logic        do_rd;
    logic [5:0]  wsel;
    logic [5:0]  rsel;
    logic        wr_en;
    logic [31:0] rd_mux;

    assign awready = ~aw_hold_ff;
    assign wready  = ~w_hold_ff;
    assign arready = ~rvalid_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign rvalid  = rvalid_ff;
    assign rdata   = rdata_ff;
    assign rresp   = rresp_ff;
    assign do_wr   = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    assign do_rd   = arvalid & ~rvalid_ff;
    assign wsel    = clksr_pkg::clksr_dec(awaddr_ff);
    assign rsel    = clksr_pkg::clksr_dec(araddr);
    // only lane 0 carries register bits; others are ignored
    assign wr_en   = do_wr & wstrb0_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_ff <= 1'b0;
            awaddr_ff  <= 12'h000;
            w_hold_ff  <= 1'b0;
            wdata_ff   <= 32'h00000000;
            wstrb0_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= clksr_pkg::RESP_OKAY;
        end
        else
        begin
            if (awvalid && !aw_hold_ff)
            begin
                aw_hold_ff <= 1'b1;
                awaddr_ff  <= awaddr;
            end
            else if (do_wr)
                aw_hold_ff <= 1'b0;
            if (wvalid && !w_hold_ff)
            begin
                w_hold_ff <= 1'b1;
                wdata_ff  <= wdata;
                wstrb0_ff <= wstrb[0];
            end
            else if (do_wr)
                w_hold_ff <= 1'b0;
            if (do_wr)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= (|wsel) ? clksr_pkg::RESP_OKAY : clksr_pkg::RESP_DEC;
            end
            else if (bready)
                bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= clksr_pkg::RESP_OKAY;
        end
        else if (do_rd)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= (|rsel) ? clksr_pkg::RESP_OKAY : clksr_pkg::RESP_DEC;
        end
        else if (rready)
            rvalid_ff <= 1'b0;
    end

    // ========================================================================
    // staged and active settings
    // ========================================================================
    logic [1:0] stg_pd_ff;
    logic       stg_pol_ff;
    logic       stg_cal_ff;
    logic [2:0] stg_rat_ff;
    logic       stg_byp_ff;
    logic       stg_src_ff;
    logic [1:0] act_pd_ff;
    logic       act_pol_ff;
    logic       act_cal_ff;
    logic [2:0] act_rat_ff;
    logic       act_byp_ff;
    logic       act_src_ff;
    logic       upd_w;
    logic [1:0] nxt_act_pd;
    logic       nxt_act_src;
    logic       pwrdn_ff;
    logic       vco_en_ff;
    logic       pre_ext_ff;

    // staged writes reach the outputs together, avoiding glitchy routing mixes
    assign upd_w       = wr_en & wsel[clksr_pkg::SEL_UPD] & wdata_ff[clksr_pkg::POS_UPD];
    assign nxt_act_pd  = upd_w ? stg_pd_ff : act_pd_ff;
    assign nxt_act_src = upd_w ? stg_src_ff : act_src_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stg_pd_ff  <= clksr_pkg::RST_PD;
            stg_pol_ff <= clksr_pkg::RST_POL;
            stg_cal_ff <= clksr_pkg::RST_CAL;
            stg_rat_ff <= clksr_pkg::RST_RATIO;
            stg_byp_ff <= clksr_pkg::RST_BYP;
            stg_src_ff <= clksr_pkg::RST_SRC;
        end
        else if (wr_en)
        begin
            if (wsel[clksr_pkg::SEL_PLL])
            begin
                stg_pd_ff  <= wdata_ff[clksr_pkg::POS_PD +: 2];
                stg_pol_ff <= wdata_ff[clksr_pkg::POS_POL];
            end
            if (wsel[clksr_pkg::SEL_CAL])
                stg_cal_ff <= wdata_ff[clksr_pkg::POS_CAL];
            if (wsel[clksr_pkg::SEL_VDIV])
                stg_rat_ff <= wdata_ff[clksr_pkg::POS_RAT +: 3];
            if (wsel[clksr_pkg::SEL_ROUTE])
            begin
                stg_byp_ff <= wdata_ff[clksr_pkg::POS_BYP];
                stg_src_ff <= wdata_ff[clksr_pkg::POS_SRC];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            act_pd_ff  <= clksr_pkg::RST_PD;
            act_pol_ff <= clksr_pkg::RST_POL;
            act_cal_ff <= clksr_pkg::RST_CAL;
            act_rat_ff <= clksr_pkg::RST_RATIO;
            act_byp_ff <= clksr_pkg::RST_BYP;
            act_src_ff <= clksr_pkg::RST_SRC;
            pwrdn_ff   <= 1'b1;
            vco_en_ff  <= 1'b0;
            pre_ext_ff <= 1'b1;
        end
        else
        begin
            if (upd_w)
            begin
                act_pol_ff <= stg_pol_ff;
                act_cal_ff <= stg_cal_ff;
                act_rat_ff <= stg_rat_ff;
                act_byp_ff <= stg_byp_ff;
            end
            act_pd_ff  <= nxt_act_pd;
            act_src_ff <= nxt_act_src;
            pwrdn_ff   <= (nxt_act_pd != clksr_pkg::PD_NORMAL);
            // unused internal vco is kept off while the external input is chosen
            vco_en_ff  <= (nxt_act_pd == clksr_pkg::PD_NORMAL) & nxt_act_src;
            pre_ext_ff <= ~nxt_act_src;
        end
    end

    assign pll_pd_field      = act_pd_ff;
    assign pll_powerdown     = pwrdn_ff;
    assign pfd_pol_neg       = act_pol_ff;
    assign vco_power_en      = vco_en_ff;
    assign prescaler_ext_sel = pre_ext_ff;

    // ========================================================================
    // register read mux (reads show staged values, status shows active)
    // ========================================================================
    logic [31:0] stat_w;

    assign stat_w = {22'h000000, vco_cal_busy, act_src_ff, act_byp_ff, act_rat_ff,
                     act_pol_ff, act_cal_ff, act_pd_ff};
    assign rd_mux = rsel[clksr_pkg::SEL_PLL]   ? {24'h000000, stg_pol_ff, 5'h00, stg_pd_ff} :
                    rsel[clksr_pkg::SEL_CAL]   ? {31'h00000000, stg_cal_ff} :
                    rsel[clksr_pkg::SEL_VDIV]  ? {29'h00000000, stg_rat_ff} :
                    rsel[clksr_pkg::SEL_ROUTE] ? {30'h00000000, stg_src_ff, stg_byp_ff} :
                    rsel[clksr_pkg::SEL_STAT]  ? stat_w : 32'h00000000;

    // ========================================================================
    // source pins, selection and divider
    // ========================================================================
    logic [1:0] sync1_ff;
    logic [1:0] sync2_ff;
    logic       src_lvl;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_ff <= 2'h0;
            sync2_ff <= 2'h0;
        end
        else
        begin
            sync1_ff <= {vco_clk_in, ext_clk_in};
            sync2_ff <= sync1_ff;
        end
    end

    assign src_lvl = act_src_ff ? sync2_ff[1] : sync2_ff[0];

    clksr_div u_div
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .src_lvl  (src_lvl),
        .ratio    (act_rat_ff),
        .bypass   (act_byp_ff),
        .dist_clk (dist_clk)
    );

    clksr_cal #(.CAL_CYCLES(CAL_CYCLES)) u_cal
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .cal_bit   (act_cal_ff),
        .cal_start (vco_cal_start),
        .cal_busy  (vco_cal_busy)
    );

    // ========================================================================
    // checks
    // ========================================================================
    default clocking cb @(posedge aclk); endclocking

    property p_rst_route;
        $past(!aresetn) |-> pll_powerdown && !act_src_ff && !act_byp_ff && pll_pd_field == 2'h1;
    endproperty
    a_rst_route: assert property (p_rst_route) else $error("reset routing wrong");

    property p_rst_vals;
        $past(!aresetn) |-> act_rat_ff == 3'h2 && stg_rat_ff == 3'h2 && !stg_byp_ff && !stg_src_ff;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset defaults wrong");

    property p_upd_apply;
        disable iff (!aresetn) upd_w |=> act_rat_ff == $past(stg_rat_ff) && act_src_ff == $past(stg_src_ff)
            && act_pd_ff == $past(stg_pd_ff);
    endproperty
    a_upd_apply: assert property (p_upd_apply) else $error("update did not apply");

    property p_upd_hold;
        disable iff (!aresetn) !upd_w |=> $stable(act_rat_ff) && $stable(act_byp_ff) && $stable(act_pol_ff);
    endproperty
    a_upd_hold: assert property (p_upd_hold) else $error("active changed without update");

    property p_vco_off;
        disable iff (!aresetn) ##1 !act_src_ff |-> !vco_power_en && prescaler_ext_sel;
    endproperty
    a_vco_off: assert property (p_vco_off) else $error("vco on while external selected");

    property p_pd_code;
        disable iff (!aresetn) ##1 pll_powerdown == (pll_pd_field != 2'h0);
    endproperty
    a_pd_code: assert property (p_pd_code) else $error("power-down code mismatch");

    property p_pol;
        disable iff (!aresetn) upd_w ##1 1'b1 |-> pfd_pol_neg == $past(stg_pol_ff);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity not from setting");

    property p_src_ext;
        disable iff (!aresetn) !act_src_ff && act_byp_ff && $stable(act_byp_ff) && $stable(act_src_ff)
            |-> dist_clk == $past(sync2_ff[0]);
    endproperty
    a_src_ext: assert property (p_src_ext) else $error("external input not routed when selected");

    property p_src_vco;
        disable iff (!aresetn) act_src_ff && act_byp_ff && $stable(act_byp_ff) && $stable(act_src_ff)
            |-> dist_clk == $past(sync2_ff[1]);
    endproperty
    a_src_vco: assert property (p_src_vco) else $error("vco not routed when selected");

    c_upd: cover property (disable iff (!aresetn) upd_w);
    c_vco_sel: cover property (disable iff (!aresetn) vco_power_en && !act_byp_ff);
    c_bypass: cover property (disable iff (!aresetn) act_byp_ff && !act_src_ff);

endmodule

// >>> sim/clksr_src.sv
`timescale 1ns/10ps
// ============================
// far side: free-running sources
// ============================
module clksr_src
#(
    parameter int EXT_HALF = 40,
    parameter int VCO_HALF = 30
)
(
    // source clocks
    output logic ext_clk,
    output logic vco_clk
);
    // oscillators never stop, so both run free
    initial
    begin
        ext_clk = 1'b0;
        vco_clk = 1'b0;
    end
    always #(EXT_HALF) ext_clk = ~ext_clk;
    always #(VCO_HALF) vco_clk = ~vco_clk;
endmodule

// >>> sim/test_clock_source_routing_control.sv
`timescale 1ns/10ps
module test_clock_source_routing_control;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, ext_clk_in, vco_clk_in, dist_clk;
    logic        pll_powerdown, pfd_pol_neg, vco_power_en, prescaler_ext_sel, vco_cal_start, vco_cal_busy;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, pll_pd_field;
    int          failures, compares, cyc, starts, busy_n, k;
    clksr_ctrl #(.CAL_CYCLES(16'h0004)) u_clksr_ctrl (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .ext_clk_in, .vco_clk_in, .dist_clk, .pll_pd_field, .pll_powerdown, .pfd_pol_neg,
        .vco_power_en, .prescaler_ext_sel, .vco_cal_start, .vco_cal_busy);
    clksr_src u_clksr_src (.ext_clk(ext_clk_in), .vco_clk(vco_clk_in));
    always #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc++;
        starts += (vco_cal_start === 1'b1);
        busy_n += (vco_cal_busy === 1'b1);
        if (cyc == 20000)
        begin
            failures++;
            summarize();
        end
    end
    // ============================
    // checks and bus tasks
    // ============================
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [11:0] ba(input logic [9:0] i);
        return {i, 2'b00};
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic done, aw, w;
        logic [1:0] r;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done)
        begin
            @(negedge aclk);
            aw = awready;
            w = wready;
            done = bvalid;
            r = bresp;
            @(posedge aclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
        // one idle edge, so bready is never lowered and raised in one step
        @(posedge aclk);
        chk("bresp", er, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        logic done, ar;
        logic [31:0] d;
        logic [1:0] r;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done)
        begin
            @(negedge aclk);
            ar = arready;
            done = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        @(posedge aclk);
        chk("rdata", e, d);
        chk("rresp", er, r);
    endtask
    // second rise-to-rise span of dist_clk, in aclk cycles; earlier ones may straddle a change
    task automatic per(input int e);
        int c, i;
        logic p, q;
        q = dist_clk;
        for (i = 0; i < 3; i++)
        begin
            c = 0;
            do
            begin
                @(negedge aclk);
                c++;
                p = q;
                q = dist_clk;
            end while (!(q === 1'b1 && p === 1'b0) && c < 400);
        end
        @(posedge aclk);
        chk("dist_period", e, c);
    endtask
    task automatic upd();
        wr(ba(clksr_pkg::IDX_UPD), 32'h1);
    endtask
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ============================
    // sequence
    // ============================
    initial
    begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        chk("pd_field", 2'h1, pll_pd_field);
        chk("powerdown", 1'b1, pll_powerdown);
        chk("ext_sel", 1'b1, prescaler_ext_sel);
        chk("pol", 1'b0, pfd_pol_neg);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ba(clksr_pkg::IDX_STAT), 32'h21);
        per(32);
        wr(ba(clksr_pkg::IDX_PLL), 32'h80);
        chk("pd_staged", 2'h1, pll_pd_field);
        upd();
        chk("pd_on", 2'h0, pll_pd_field);
        chk("pol_neg", 1'b1, pfd_pol_neg);
        chk("vco_off", 1'b0, vco_power_en);
        chk("ext_pre", 1'b1, prescaler_ext_sel);
        rd(ba(clksr_pkg::IDX_PLL), 32'h80);
        rd(ba(clksr_pkg::IDX_UPD), 32'h0);
        for (k = 0; k < 5; k++)
        begin
            wr(ba(clksr_pkg::IDX_VDIV), k);
            upd();
            per((k + 2) * 8);
        end
        wr(ba(clksr_pkg::IDX_ROUTE), 32'h1);
        upd();
        per(8);
        wr(ba(clksr_pkg::IDX_VDIV), 32'h0);
        wr(ba(clksr_pkg::IDX_ROUTE), 32'h2);
        upd();
        chk("vco_on", 1'b1, vco_power_en);
        chk("ext_pre", 1'b0, prescaler_ext_sel);
        per(12);
        wr(ba(clksr_pkg::IDX_CAL), 32'h1);
        upd();
        repeat (8) @(posedge aclk);
        chk("cal_starts", 1, starts);
        chk("cal_busy", 4, busy_n);
        wr(ba(clksr_pkg::IDX_CAL), 32'h0);
        upd();
        wr(ba(clksr_pkg::IDX_CAL), 32'h1);
        upd();
        repeat (8) @(posedge aclk);
        chk("cal_starts", 2, starts);
        chk("cal_busy", 8, busy_n);
        wr(12'h004, 32'h1, clksr_pkg::RESP_DEC);
        rd(12'h004, 32'h0, clksr_pkg::RESP_DEC);
        summarize();
    end
endmodule
